/* pkg/bec_map.svh */
// Offsets, field positions, reset values and sync depth for the block enable register
`ifndef BEC_MAP_SVH
`define BEC_MAP_SVH

`define BEC_ADDR_ENABLE_ONE 8'h1D
`define BEC_RESET_BYTE 8'h00
`define BEC_BIT_ACTIVE 7
`define BEC_BIT_SLEEP 6
`define BEC_BIT_MICBIAS 4
`define BEC_BIT_MICAMP 3
`define BEC_BIT_SCAN 2
`define BEC_AUTO_OFF 2'h0
`define BEC_AUTO_ONE 2'h1
`define BEC_AUTO_TWO 2'h2
`define BEC_SYNC_STAGES 3
`define BEC_PIN_COUNT 3
`define BEC_PIN_SWITCH 0
`define BEC_PIN_PRESENT 1
`define BEC_PIN_BUTTON 2

`endif

/* pkg/bec_pkg.sv */
// Types shared by the block enable register logic
package bec_pkg;
    typedef enum logic [1:0] {
        BEC_OFF = 2'b00,
        BEC_IDENT = 2'b01,
        BEC_RUN = 2'b10,
        BEC_SLEEP = 2'b11
    } bec_mode_t;
endpackage : bec_pkg

/* verilog/bec_block_enable.sv */
// Block enable register one: host control, auto-config override and power modes
`timescale 1ns/1ps
`include "bec_map.svh"

// Contract
// - In either automatic setting, host writes to the mic bias and mic preamp bits are ignored.
// - In automatic setting, the mic bias and mic preamp bits read back the device-chosen block states.
// - Removal sensing runs once a jack is seen inserted, regardless of enables.
// - Active control at 0 holds lowest-power shutdown, only insertion or removal sensing runs.
// - Active control rising to 1 powers up and starts jack identification at once.
// - In shutdown a broken jack switch reports an accessory as inserted.
// - With active control at 0 the sleep-watch bit is ignored entirely.
// - Sleep-watch button press sets the flag; interrupt only when mask set.
// - Sleep-watch cleared gives normal mode while active control stays set.
// - Bit 4 drives mic bias; host-written outside auto, reports device state inside.
// - Bit 3 drives mic preamp; host-written outside auto, reports device state inside.
// - Bit 2 reports key-scan converter state and is read-only always.
module bec_block_enable
    import bec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Automatic configuration state
    input wire logic [1:0] autoField,
    input wire logic autoMicBias,
    input wire logic autoMicAmp,
    input wire logic buttonScanAdcOn,
    // Jack pins, asynchronous
    input wire logic jackSwitchClosed,
    input wire logic accessorySensed,
    input wire logic buttonSensed,
    input wire logic jackSwitchBroken,
    // Status side
    input wire logic buttonPressIrqMask,
    input wire logic buttonPressFlagClr,
    output logic buttonPressFlag,
    output logic buttonPressIrq,
    // Block controls
    output logic deviceActive,
    output logic sleepWatchOn,
    output logic micBiasOn,
    output logic micAmpOn,
    output logic insertSenseOn,
    output logic removalSenseOn,
    output logic jackInserted,
    output logic identifyStart
);

    // Pin synchronisers: the first stage feeds only the second
    logic [`BEC_PIN_COUNT-1:0] pinRaw;
    logic [`BEC_PIN_COUNT-1:0] pinValue;
    assign pinRaw = {buttonSensed, accessorySensed, jackSwitchClosed};

    genvar gi;
    generate
        for (gi = 0; gi < `BEC_PIN_COUNT; gi = gi + 1) begin : g_sync
            logic [`BEC_SYNC_STAGES-1:0] stage_reg;
            logic [`BEC_SYNC_STAGES-1:0] stage_next;
            logic value_reg;
            logic value_next;
            always_comb begin
                stage_next = {stage_reg[`BEC_SYNC_STAGES-2:0], pinRaw[gi]};
                // Only a level seen by both late stages counts, filtering one-stage glitches
                value_next = (stage_reg[`BEC_SYNC_STAGES-2] == stage_reg[`BEC_SYNC_STAGES-1]) ?
                             stage_reg[`BEC_SYNC_STAGES-1] : value_reg;
            end
            always_ff @(posedge clk) begin
                if (reset) begin
                    stage_reg <= '0;
                    value_reg <= 1'b0;
                end else begin
                    stage_reg <= stage_next;
                    value_reg <= value_next;
                end
            end
            assign pinValue[gi] = value_reg;
        end
    endgenerate

    // Host-held register bits
    logic activeCtl_reg, activeCtl_next;
    logic sleepCtl_reg, sleepCtl_next;
    logic micBiasCtl_reg, micBiasCtl_next;
    logic micAmpCtl_reg, micAmpCtl_next;
    logic autoOn;
    logic regHit;

    assign autoOn = (autoField == `BEC_AUTO_ONE) || (autoField == `BEC_AUTO_TWO);
    assign regHit = (regAddr == `BEC_ADDR_ENABLE_ONE);

    always_comb begin
        activeCtl_next = activeCtl_reg;
        sleepCtl_next = sleepCtl_reg;
        micBiasCtl_next = micBiasCtl_reg;
        micAmpCtl_next = micAmpCtl_reg;
        if (regWrEn && regHit) begin
            activeCtl_next = regWrData[`BEC_BIT_ACTIVE];
            sleepCtl_next = regWrData[`BEC_BIT_SLEEP];
            if (!autoOn) begin
                micBiasCtl_next = regWrData[`BEC_BIT_MICBIAS];
                micAmpCtl_next = regWrData[`BEC_BIT_MICAMP];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            activeCtl_reg <= 1'b0;
            sleepCtl_reg <= 1'b0;
            micBiasCtl_reg <= 1'b0;
            micAmpCtl_reg <= 1'b0;
        end else begin
            activeCtl_reg <= activeCtl_next;
            sleepCtl_reg <= sleepCtl_next;
            micBiasCtl_reg <= micBiasCtl_next;
            micAmpCtl_reg <= micAmpCtl_next;
        end
    end

    // Power mode
    bec_mode_t mode_reg, mode_next;

    always_comb begin
        case (mode_reg)
            BEC_OFF: mode_next = activeCtl_reg ? BEC_IDENT : BEC_OFF;
            BEC_IDENT: mode_next = !activeCtl_reg ? BEC_OFF :
                                   (sleepCtl_reg ? BEC_SLEEP : BEC_RUN);
            BEC_RUN: mode_next = !activeCtl_reg ? BEC_OFF :
                                 (sleepCtl_reg ? BEC_SLEEP : BEC_RUN);
            BEC_SLEEP: mode_next = !activeCtl_reg ? BEC_OFF :
                                   (sleepCtl_reg ? BEC_SLEEP : BEC_RUN);
            default: mode_next = BEC_OFF;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_reg <= BEC_OFF;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Effective block states and outputs
    logic micBiasEff, micAmpEff;
    logic jackNext;
    logic buttonPrev_reg;
    logic buttonEdge;
    logic powered;

    assign powered = (mode_next != BEC_OFF);
    assign micBiasEff = autoOn ? autoMicBias : micBiasCtl_reg;
    assign micAmpEff = autoOn ? autoMicAmp : micAmpCtl_reg;
    assign buttonEdge = pinValue[`BEC_PIN_BUTTON] && !buttonPrev_reg;

    always_comb begin
        case (mode_next)
            // Mechanical switch only; a broken one can only report inserted
            BEC_OFF: jackNext = jackSwitchBroken || pinValue[`BEC_PIN_SWITCH];
            // Electrical sensing covers a broken switch
            BEC_SLEEP: jackNext = pinValue[`BEC_PIN_PRESENT];
            default: jackNext = jackSwitchBroken ? pinValue[`BEC_PIN_PRESENT] :
                                pinValue[`BEC_PIN_SWITCH];
        endcase
    end

    logic [7:0] rdNext;
    logic flagNext;

    always_comb begin
        rdNext = `BEC_RESET_BYTE;
        if (regRdEn && regHit) begin
            rdNext[`BEC_BIT_ACTIVE] = activeCtl_reg;
            rdNext[`BEC_BIT_SLEEP] = sleepCtl_reg;
            rdNext[`BEC_BIT_MICBIAS] = micBiasEff;
            rdNext[`BEC_BIT_MICAMP] = micAmpEff;
            rdNext[`BEC_BIT_SCAN] = buttonScanAdcOn;
        end
        // Set beats a clear landing in the same cycle
        flagNext = (buttonPressFlag && !buttonPressFlagClr) ||
                   ((mode_reg == BEC_SLEEP) && buttonEdge);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            regRdData <= `BEC_RESET_BYTE;
            buttonPrev_reg <= 1'b0;
            buttonPressFlag <= 1'b0;
            buttonPressIrq <= 1'b0;
            deviceActive <= 1'b0;
            sleepWatchOn <= 1'b0;
            micBiasOn <= 1'b0;
            micAmpOn <= 1'b0;
            insertSenseOn <= 1'b0;
            removalSenseOn <= 1'b0;
            jackInserted <= 1'b0;
            identifyStart <= 1'b0;
        end else begin
            regRdData <= rdNext;
            buttonPrev_reg <= pinValue[`BEC_PIN_BUTTON];
            buttonPressFlag <= flagNext;
            buttonPressIrq <= flagNext && buttonPressIrqMask;
            deviceActive <= powered;
            sleepWatchOn <= (mode_next == BEC_SLEEP);
            // Shutdown gates mic bias and mic amp off
            micBiasOn <= powered && micBiasEff;
            micAmpOn <= powered && micAmpEff;
            insertSenseOn <= !jackNext;
            removalSenseOn <= jackNext;
            jackInserted <= jackNext;
            identifyStart <= (mode_next == BEC_IDENT);
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_activeRise;
        (mode_reg == BEC_OFF) && activeCtl_reg;
    endsequence

    sequence s_identPulse;
        identifyStart ##1 !identifyStart;
    endsequence

    chk_auto_write_block: assert property (
        (regWrEn && regHit && autoOn) |=> $stable(micBiasCtl_reg) && $stable(micAmpCtl_reg))
        else $error("auto mode let a host write reach an enable bit");

    chk_auto_read_back: assert property (
        (regRdEn && regHit && autoOn) |=>
            regRdData[`BEC_BIT_MICBIAS] == $past(autoMicBias))
        else $error("auto mode read does not show device mic bias state");

    chk_removal_follows_jack: assert property (
        removalSenseOn == jackInserted)
        else $error("removal sensing not tied to inserted jack");

    chk_shutdown_all_off: assert property (
        (!activeCtl_reg && !$past(activeCtl_reg)) |=> !micBiasOn && !micAmpOn && !deviceActive)
        else $error("block powered while active control low");

    chk_ident_on_rise: assert property (
        s_activeRise |=> s_identPulse)
        else $error("identification did not start right after power up");

    chk_broken_reports_in: assert property (
        (mode_next == BEC_OFF && jackSwitchBroken) |=> jackInserted)
        else $error("broken switch in shutdown not reported as inserted");

    chk_sleep_ignored_off: assert property (
        (!activeCtl_reg) |=> !sleepWatchOn)
        else $error("sleep watch ran with active control low");

    chk_flag_on_press: assert property (
        (mode_reg == BEC_SLEEP && buttonEdge) |=> buttonPressFlag ##0
            (buttonPressIrq == $past(buttonPressIrqMask)))
        else $error("button press in sleep watch not flagged correctly");

    chk_normal_mode: assert property (
        (activeCtl_reg && !sleepCtl_reg && mode_reg != BEC_OFF) |=> !sleepWatchOn)
        else $error("sleep watch on with enable cleared");

    chk_reserved_zero: assert property (
        regRdData[5] == 1'b0 && regRdData[1:0] == 2'h0)
        else $error("reserved bits read nonzero");

    chk_auto_amp_back: assert property (
        (regRdEn && regHit && autoOn) |=> regRdData[`BEC_BIT_MICAMP] == $past(autoMicAmp))
        else $error("auto mode read does not show device mic amp state");

    chk_removal_when_in: assert property (
        (mode_next == BEC_RUN && !jackSwitchBroken && pinValue[`BEC_PIN_SWITCH]) |=> removalSenseOn)
        else $error("removal sensing off with a jack inserted");

    chk_sleep_jack_present: assert property (
        (mode_next == BEC_SLEEP) |=> jackInserted == $past(pinValue[`BEC_PIN_PRESENT]))
        else $error("sleep watch jack status not from electrical sensing");

    // A clear held over a new press must not swallow it
    chk_flag_set_wins: assert property (
        (mode_reg == BEC_SLEEP && buttonEdge && buttonPressFlagClr) |=> buttonPressFlag)
        else $error("clear beat a button press in the same cycle");

    chk_manual_bias_write: assert property (
        (regWrEn && regHit && !autoOn) |=> micBiasCtl_reg == $past(regWrData[`BEC_BIT_MICBIAS]))
        else $error("manual write did not reach mic bias bit");

    chk_manual_amp_write: assert property (
        (regWrEn && regHit && !autoOn) |=> micAmpCtl_reg == $past(regWrData[`BEC_BIT_MICAMP]))
        else $error("manual write did not reach mic amp bit");

    chk_scan_read_only: assert property (
        (regRdEn && regHit) |=> regRdData[`BEC_BIT_SCAN] == $past(buttonScanAdcOn))
        else $error("scan bit does not report converter state");

    chk_idle_read_zero: assert property (
        !(regRdEn && regHit) |=> regRdData == `BEC_RESET_BYTE)
        else $error("read data not zero outside a register read");

endmodule : bec_block_enable

/* sim/bec_host_model.sv */
// Host processor model: register port and the auto field of the second enable register
`timescale 1ns/1ps
`include "bec_map.svh"
module bec_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic regWrEn = 1'h0,
    output logic regRdEn = 1'h0,
    output logic [7:0] regAddr = 8'h00,
    output logic [7:0] regWrData = 8'h00,
    input wire logic [7:0] regRdData,
    // Auto field and insertion status
    output logic [1:0] autoField = 2'h0,
    input wire logic jackInserted
);
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #2;
        regAddr = addr;
        regWrData = data;
        regWrEn = 1'h1;
        @(posedge clk);
        #2;
        regWrEn = 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        #2;
        regAddr = addr;
        regRdEn = 1'h1;
        @(posedge clk);
        #2;
        regRdEn = 1'h0;
        data = regRdData;
    endtask : rd
    task automatic setAuto(input logic [1:0] f);
        @(posedge clk);
        #2;
        autoField = f;
    endtask : setAuto
    // Power up only after insertion; bounded so a dead status line cannot hang
    task automatic wake(input logic [7:0] data, output bit seen);
        seen = 1'h0;
        for (int i = 0; i < 20 && !seen; i++) begin
            @(posedge clk);
            #2;
            seen = (jackInserted === 1'h1);
        end
        if (seen) begin
            wr(`BEC_ADDR_ENABLE_ONE, data);
        end
    endtask : wake
    task automatic sleepSetup(input logic [7:0] data);
        wr(`BEC_ADDR_ENABLE_ONE, data);
        setAuto(`BEC_AUTO_OFF);
        setAuto(`BEC_AUTO_ONE);
    endtask : sleepSetup
endmodule : bec_host_model

/* sim/tb_top.sv */
// Self-checking bench for the block enable register
`timescale 1ns/1ps
`include "bec_map.svh"
module tb_top;
    typedef struct {
        logic [1:0] auto;
        logic [7:0] addr;
        logic [7:0] data;
        logic bias;
        logic amp;
        logic scan;
        logic [7:0] exp;
    } bec_row_t;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic regWrEn, regRdEn;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [1:0] autoField;
    logic autoMicBias = 1'h0, autoMicAmp = 1'h0, buttonScanAdcOn = 1'h0;
    logic jackSwitchClosed = 1'h0, accessorySensed = 1'h0, buttonSensed = 1'h0;
    logic jackSwitchBroken = 1'h0, buttonPressIrqMask = 1'h0, buttonPressFlagClr = 1'h0;
    logic buttonPressFlag, buttonPressIrq, deviceActive, sleepWatchOn, micBiasOn, micAmpOn;
    logic insertSenseOn, removalSenseOn, jackInserted, identifyStart;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    // Rows run in order: row 5 relies on bits 4,3 kept from row 2
    bec_row_t rows[6] = '{
        '{2'h0, 8'h1D, 8'hFF, 1'h0, 1'h0, 1'h0, 8'hD8},
        '{2'h0, 8'h1D, 8'h00, 1'h0, 1'h0, 1'h1, 8'h04},
        '{2'h3, 8'h1D, 8'h18, 1'h0, 1'h0, 1'h0, 8'h18},
        '{2'h1, 8'h1D, 8'h00, 1'h1, 1'h0, 1'h0, 8'h10},
        '{2'h2, 8'h1D, 8'hFF, 1'h0, 1'h1, 1'h1, 8'hCC},
        '{2'h0, 8'h1C, 8'h00, 1'h0, 1'h0, 1'h0, 8'hD8}
    };
    always #10 clk = ~clk;
    bec_host_model host (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .autoField(autoField), .jackInserted(jackInserted));
    bec_block_enable dut (.clk(clk), .reset(reset), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .autoField(autoField), .autoMicBias(autoMicBias),
        .autoMicAmp(autoMicAmp), .buttonScanAdcOn(buttonScanAdcOn),
        .jackSwitchClosed(jackSwitchClosed), .accessorySensed(accessorySensed),
        .buttonSensed(buttonSensed), .jackSwitchBroken(jackSwitchBroken),
        .buttonPressIrqMask(buttonPressIrqMask), .buttonPressFlagClr(buttonPressFlagClr),
        .buttonPressFlag(buttonPressFlag), .buttonPressIrq(buttonPressIrq),
        .deviceActive(deviceActive), .sleepWatchOn(sleepWatchOn), .micBiasOn(micBiasOn),
        .micAmpOn(micAmpOn), .insertSenseOn(insertSenseOn),
        .removalSenseOn(removalSenseOn), .jackInserted(jackInserted),
        .identifyStart(identifyStart));
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
            n_fail++;
        end
    endtask : check
    task automatic bit1(input logic got, input logic exp, input string what);
        check({7'h00, got}, {7'h00, exp}, what);
    endtask : bit1
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : settle
    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // Whole run is well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            $display("ERROR %0t timeout", $time);
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        logic [7:0] rdv;
        bit seen;
        int hi;
        settle(5);
        reset = 1'h0;
        host.rd(`BEC_ADDR_ENABLE_ONE, rdv);
        check(rdv, `BEC_RESET_BYTE, "reset value");
        host.rd(8'h1C, rdv);
        check(rdv, 8'h00, "unmapped read");
        foreach (rows[i]) begin
            host.setAuto(rows[i].auto);
            autoMicBias = rows[i].bias;
            autoMicAmp = rows[i].amp;
            buttonScanAdcOn = rows[i].scan;
            host.wr(rows[i].addr, rows[i].data);
            host.rd(`BEC_ADDR_ENABLE_ONE, rdv);
            check(rdv, rows[i].exp, "row readback");
        end
        host.setAuto(`BEC_AUTO_OFF);
        host.wr(`BEC_ADDR_ENABLE_ONE, 8'h58);
        jackSwitchBroken = 1'h1;
        settle(6);
        bit1(jackInserted, 1'h1, "broken switch");
        bit1(removalSenseOn, 1'h1, "removal sense");
        bit1(deviceActive, 1'h0, "shutdown");
        bit1(micBiasOn, 1'h0, "bias in shutdown");
        bit1(sleepWatchOn, 1'h0, "sleep ignored");
        jackSwitchBroken = 1'h0;
        settle(6);
        bit1(insertSenseOn, 1'h1, "insert sense");
        jackSwitchClosed = 1'h1;
        host.wake(8'h98, seen);
        bit1(seen, 1'h1, "insertion seen");
        hi = 0;
        repeat (6) begin
            settle(1);
            hi += (identifyStart === 1'h1);
        end
        check(hi[7:0], 8'h01, "identify pulse");
        bit1(sleepWatchOn, 1'h0, "normal mode");
        bit1(micBiasOn, 1'h1, "bias on");
        bit1(micAmpOn, 1'h1, "amp on");
        bit1(removalSenseOn, 1'h1, "removal sense");
        host.sleepSetup(8'hC0);
        jackSwitchBroken = 1'h1;
        settle(6);
        bit1(sleepWatchOn, 1'h1, "sleep mode");
        bit1(jackInserted, 1'h0, "sleep absent");
        accessorySensed = 1'h1;
        buttonSensed = 1'h1;
        settle(7);
        bit1(jackInserted, 1'h1, "sleep present");
        bit1(buttonPressFlag, 1'h1, "button flag");
        bit1(buttonPressIrq, 1'h0, "masked irq");
        buttonPressIrqMask = 1'h1;
        settle(2);
        bit1(buttonPressIrq, 1'h1, "unmasked irq");
        buttonSensed = 1'h0;
        buttonPressFlagClr = 1'h1;
        settle(1);
        buttonPressFlagClr = 1'h0;
        settle(1);
        bit1(buttonPressFlag, 1'h0, "flag cleared");
        settle(4);
        buttonSensed = 1'h1;
        buttonPressFlagClr = 1'h1;
        settle(5);
        bit1(buttonPressFlag, 1'h1, "set beats clear");
        buttonPressFlagClr = 1'h0;
        reset = 1'h1;
        settle(2);
        reset = 1'h0;
        host.rd(`BEC_ADDR_ENABLE_ONE, rdv);
        check(rdv, `BEC_RESET_BYTE, "second reset");
        end_of_test();
    end
endmodule : tb_top
